/* File: design/exec_unit_pkg.sv */
package exec_unit_pkg;
   // register offsets, byte addresses
   localparam int          PADDR_W     = 8;
   localparam logic [7:0]  CMD_OFS     = 8'h00;
   localparam logic [7:0]  OPERAND_OFS = 8'h04;
   localparam logic [7:0]  FLAGS_OFS   = 8'h08;
   localparam logic [7:0]  ADDR_OFS    = 8'h0C;
   localparam logic [7:0]  STATE_OFS   = 8'h10;
   // command word fields
   localparam int          OP_W        = 6;
   localparam int          CMD_BIT_LSB = 8;
   localparam int          CMD_BASE_LSB = 12;
   localparam int          BASE_W      = 3;
   localparam int          CMD_NVM_BIT = 16;
   localparam int          CMD_IOSP_BIT = 17;
   localparam int          STATE_BUSY_BIT = 8;
   // status flag positions
   localparam int          FLAG_C = 0;
   localparam int          FLAG_Z = 1;
   localparam int          FLAG_N = 2;
   localparam int          FLAG_V = 3;
   localparam int          FLAG_S = 4;
   localparam int          FLAG_H = 5;
   localparam int          FLAG_T = 6;
   localparam int          FLAG_I = 7;
   // reset values and sizes
   localparam logic [7:0]  FLAGS_RESET = 8'h00;
   localparam logic [7:0]  BYTE_ZERO   = 8'h00;
   localparam logic [7:0]  IO_LOW_SIZE = 8'h40;
   localparam logic [7:0]  CYCLE_ONE   = 8'h01;
   localparam int          CNT_W       = 8;

   typedef enum logic [5:0] {
      nop_op                 = 6'h00,
      logical_shift_left_op  = 6'h01,
      logical_shift_right_op = 6'h02,
      rotate_left_carry_op   = 6'h03,
      rotate_right_carry_op  = 6'h04,
      arith_shift_right_op   = 6'h05,
      nibble_swap_op         = 6'h06,
      io_bit_set_op          = 6'h07,
      io_bit_clear_op        = 6'h08,
      bit_to_transfer_op     = 6'h09,
      transfer_to_bit_op     = 6'h0A,
      generic_flag_set_op    = 6'h0B,
      generic_flag_clear_op  = 6'h0C,
      carry_set_op           = 6'h0D,
      carry_clear_op         = 6'h0E,
      negative_set_op        = 6'h0F,
      negative_clear_op      = 6'h10,
      zero_set_op            = 6'h11,
      zero_clear_op          = 6'h12,
      irq_enable_op          = 6'h13,
      irq_disable_op         = 6'h14,
      signed_set_op          = 6'h15,
      signed_clear_op        = 6'h16,
      overflow_set_op        = 6'h17,
      overflow_clear_op      = 6'h18,
      transfer_set_op        = 6'h19,
      transfer_clear_op      = 6'h1A,
      halfcarry_set_op       = 6'h1B,
      halfcarry_clear_op     = 6'h1C,
      break_op               = 6'h1D,
      sleep_op               = 6'h1E,
      watchdog_restart_op    = 6'h1F,
      data_access_op         = 6'h20
   } op_t;

   typedef enum logic [1:0] {
      st_idle     = 2'b00,
      st_exec     = 2'b01,
      st_io_write = 2'b10,
      st_mem_wait = 2'b11
   } state_t;
endpackage

/* File: design/access_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module access_timer
   import exec_unit_pkg::*;
#(
   parameter int BW = BASE_W
) (
   input  wire logic          clk,       // core clock
   input  wire logic          reset,     // async, active high
   input  wire logic          start,     // load on first cycle
   input  wire logic [BW-1:0] base,      // listed cycle count
   input  wire logic          via_nvm,   // routed through controller
   input  wire logic          low_io,    // lower i/o space target
   input  wire logic          nvm_busy,  // controller stall
   output logic               needs_wait, // more than one cycle
   output logic               done        // last waiting cycle
);
   logic [BW+1:0] remaining;
   logic [BW+1:0] next_remaining;
   logic [BW+1:0] total;

   // total cycles including the extra ones
   always_comb begin
      total = (BW+2)'(base) + (BW+2)'(low_io) + (BW+2)'(via_nvm);
      if (total == '0) begin
         total = (BW+2)'(1);
      end
      needs_wait = (total > (BW+2)'(1));
      done = (remaining == '0) && !(via_nvm && nvm_busy);
      next_remaining = remaining;
      if (start) begin
         next_remaining = needs_wait ? total - (BW+2)'(2) : '0;
      end else if (remaining != '0) begin
         next_remaining = remaining - (BW+2)'(1);
      end
   end

   // countdown register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         remaining <= '0;
      end else begin
         remaining <= next_remaining;
      end
   end
endmodule
`default_nettype wire

/* File: design/bit_shift_flag_exec_unit.sv */
// Operation
// - rotate left through carry: carry into bit0, bit7 to carry, one cycle
// - rotate right through carry: carry into bit7, bit0 out, no H
// - i/o bit set forces chosen bit to one, flags kept, two cycles
// - i/o bit clear forces chosen bit to zero, no flag, two cycles
// - bit to transfer copies register bit into T, one cycle
// - transfer to bit writes T into register bit, one cycle
// - overflow set and clear touch only V, one cycle
// - half carry set and clear touch only H, one cycle
// - signed set and clear touch only S, one cycle
// - break takes one cycle, no flags, signals debug facility
// - sleep takes one cycle, no flags, requests sleep state
// - watchdog restart takes one cycle, no flags, restarts watchdog
// - listed data access counts hold for internal ram only
// - controller-routed access adds one cycle, more while it is busy
// - access to lowest 64 i/o bytes adds one cycle
`timescale 1ns/1ps
`default_nettype none
module bit_shift_flag_exec_unit
   import exec_unit_pkg::*;
#(
   parameter int IO_AW = 8
) (
   input  wire logic               clk,         // core clock
   input  wire logic               reset,       // async, active high
   input  wire logic               psel,        // apb select
   input  wire logic               penable,     // apb access phase
   input  wire logic               pwrite,      // apb direction
   input  wire logic [PADDR_W-1:0] paddr,       // apb byte address
   input  wire logic [31:0]        pwdata,      // apb write data
   output logic      [31:0]        prdata,      // apb read data
   output logic                    pready,      // apb ready
   output logic                    pslverr,     // apb error
   input  wire logic [7:0]         io_rdata,    // i/o read data
   input  wire logic               nvm_busy,    // controller busy
   output logic      [IO_AW-1:0]   io_addr,     // i/o address
   output logic      [7:0]         io_wdata,    // i/o write data
   output logic                    io_re,       // i/o read strobe
   output logic                    io_we,       // i/o write strobe
   output logic                    debug_break, // debug entry pulse
   output logic                    sleep_req,   // sleep request pulse
   output logic                    wdt_restart  // watchdog restart pulse
);
   state_t           state, next_state;
   op_t              op, next_op;
   logic [2:0]       bsel, next_bsel;
   logic [BASE_W-1:0] base, next_base;
   logic             nonvolatile_mem_controller, next_nvm, iosp, next_iosp;
   logic [7:0]       rd, next_rd, flags, next_flags;
   logic [IO_AW-1:0] next_io_addr;
   logic [7:0]       next_io_wdata;
   logic             next_io_re, next_io_we;
   logic             next_debug_break, next_sleep_req, next_wdt_restart;
   logic [CNT_W-1:0] last_cycles, next_last_cycles;
   logic [31:0]      next_prdata;
   logic             next_pready, next_pslverr;
   logic             wr_ok, setup, mapped, low_io, t_start, t_done, t_wait;
   logic [7:0]       sh_res;
   logic             sh_c;
   logic [4:0]       fl_hit;

   // dedicated flag op decode: {hit, value, index}
   function automatic logic [4:0] flag_op(input op_t o);
      unique case (o)
         carry_set_op:      flag_op = {2'b11, 3'(FLAG_C)};
         carry_clear_op:    flag_op = {2'b10, 3'(FLAG_C)};
         negative_set_op:   flag_op = {2'b11, 3'(FLAG_N)};
         negative_clear_op: flag_op = {2'b10, 3'(FLAG_N)};
         zero_set_op:       flag_op = {2'b11, 3'(FLAG_Z)};
         zero_clear_op:     flag_op = {2'b10, 3'(FLAG_Z)};
         irq_enable_op:     flag_op = {2'b11, 3'(FLAG_I)};
         irq_disable_op:    flag_op = {2'b10, 3'(FLAG_I)};
         signed_set_op:     flag_op = {2'b11, 3'(FLAG_S)};
         signed_clear_op:   flag_op = {2'b10, 3'(FLAG_S)};
         overflow_set_op:   flag_op = {2'b11, 3'(FLAG_V)};
         overflow_clear_op: flag_op = {2'b10, 3'(FLAG_V)};
         transfer_set_op:   flag_op = {2'b11, 3'(FLAG_T)};
         transfer_clear_op: flag_op = {2'b10, 3'(FLAG_T)};
         halfcarry_set_op:  flag_op = {2'b11, 3'(FLAG_H)};
         halfcarry_clear_op: flag_op = {2'b10, 3'(FLAG_H)};
         default:           flag_op = 5'h00;
      endcase
   endfunction

   assign setup = psel && !penable;
   assign wr_ok = psel && penable && pready && pwrite && !pslverr;
   assign low_io = iosp && (io_addr < IO_AW'(IO_LOW_SIZE));
   assign t_start = (state == st_exec) && (op == data_access_op);
   assign fl_hit = flag_op(op); // dedicated flag op decode of current op

   access_timer #(.BW(BASE_W)) timer (
      .clk        (clk),
      .reset      (reset),
      .start      (t_start),
      .base       (base),
      .via_nvm    (nonvolatile_mem_controller),
      .low_io     (low_io),
      .nvm_busy   (nvm_busy),
      .needs_wait (t_wait),
      .done       (t_done)
   );

   // apb answer: ready in the first access cycle
   always_comb begin
      mapped = (paddr == CMD_OFS) || (paddr == OPERAND_OFS) ||
               (paddr == FLAGS_OFS) || (paddr == ADDR_OFS) ||
               (paddr == STATE_OFS);
      next_pready = setup;
      next_pslverr = setup && (!mapped || (pwrite && state != st_idle));
      next_prdata = '0;
      if (setup && !pwrite) begin
         unique case (paddr)
            CMD_OFS:     next_prdata = {26'h0, op};
            OPERAND_OFS: next_prdata = {24'h0, rd};
            FLAGS_OFS:   next_prdata = {24'h0, flags};
            ADDR_OFS:    next_prdata = 32'(io_addr);
            STATE_OFS:   next_prdata = {23'h0, state != st_idle,
                                        last_cycles};
            default:     next_prdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= next_pready;
         pslverr <= next_pslverr;
         prdata <= next_prdata;
      end
   end

   // shifter for the five shift and rotate forms
   always_comb begin
      sh_res = rd;
      sh_c = flags[FLAG_C];
      unique case (op)
         logical_shift_left_op: begin
            sh_res = {rd[6:0], 1'b0};
            sh_c = rd[7];
         end
         rotate_left_carry_op: begin
            sh_res = {rd[6:0], flags[FLAG_C]};
            sh_c = rd[7];
         end
         logical_shift_right_op: begin
            sh_res = {1'b0, rd[7:1]};
            sh_c = rd[0];
         end
         rotate_right_carry_op: begin
            sh_res = {flags[FLAG_C], rd[7:1]};
            sh_c = rd[0];
         end
         arith_shift_right_op: begin
            sh_res = {rd[7], rd[7:1]};
            sh_c = rd[0];
         end
         default: begin
            sh_res = rd;
            sh_c = flags[FLAG_C];
         end
      endcase
   end

   // execution sequencer and operand state
   always_comb begin
      next_state = state;
      next_op = op;
      next_bsel = bsel;
      next_base = base;
      next_nvm = nonvolatile_mem_controller;
      next_iosp = iosp;
      next_rd = rd;
      next_flags = flags;
      next_io_addr = io_addr;
      next_io_wdata = io_wdata;
      next_io_re = 1'b0;
      next_io_we = 1'b0;
      next_debug_break = 1'b0;
      next_sleep_req = 1'b0;
      next_wdt_restart = 1'b0;
      next_last_cycles = last_cycles;
      if (state != st_idle) begin
         next_last_cycles = last_cycles + CYCLE_ONE;
      end
      if (wr_ok) begin
         unique case (paddr)
            CMD_OFS: begin
               next_op = op_t'(pwdata[OP_W-1:0]);
               next_bsel = pwdata[CMD_BIT_LSB +: 3];
               next_base = pwdata[CMD_BASE_LSB +: BASE_W];
               next_nvm = pwdata[CMD_NVM_BIT];
               next_iosp = pwdata[CMD_IOSP_BIT];
               next_last_cycles = '0;
               next_state = st_exec;
            end
            OPERAND_OFS: next_rd = pwdata[7:0];
            FLAGS_OFS:   next_flags = pwdata[7:0];
            ADDR_OFS:    next_io_addr = pwdata[IO_AW-1:0];
            default:     next_rd = rd;
         endcase
      end
      unique case (state)
         st_idle: begin
         end
         st_exec: begin
            next_state = st_idle;
            unique case (op)
               logical_shift_left_op, rotate_left_carry_op,
               logical_shift_right_op, rotate_right_carry_op,
               arith_shift_right_op: begin
                  next_rd = sh_res;
                  next_flags[FLAG_Z] = (sh_res == BYTE_ZERO);
                  next_flags[FLAG_C] = sh_c;
                  next_flags[FLAG_N] = sh_res[7];
                  next_flags[FLAG_V] = sh_res[7] ^ sh_c;
                  if (op == logical_shift_left_op ||
                      op == rotate_left_carry_op) begin
                     next_flags[FLAG_H] = rd[3];
                  end
               end
               nibble_swap_op: next_rd = {rd[3:0], rd[7:4]};
               io_bit_set_op, io_bit_clear_op: begin
                  next_io_re = 1'b1;
                  next_state = st_io_write;
               end
               bit_to_transfer_op: next_flags[FLAG_T] = rd[bsel];
               transfer_to_bit_op: next_rd[bsel] = flags[FLAG_T];
               generic_flag_set_op: next_flags[bsel] = 1'b1;
               generic_flag_clear_op: next_flags[bsel] = 1'b0;
               break_op: next_debug_break = 1'b1;
               sleep_op: next_sleep_req = 1'b1;
               watchdog_restart_op: next_wdt_restart = 1'b1;
               data_access_op: begin
                  if (t_wait) begin
                     next_state = st_mem_wait;
                  end
               end
               default: begin
                  if (fl_hit[4]) begin
                     next_flags[fl_hit[2:0]] = fl_hit[3];
                  end
               end
            endcase
         end
         st_io_write: begin
            next_io_wdata = io_rdata;
            next_io_wdata[bsel] = (op == io_bit_set_op);
            next_io_we = 1'b1;
            next_state = st_idle;
         end
         st_mem_wait: begin
            if (t_done) begin
               next_state = st_idle;
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= st_idle;
         op <= nop_op;
         bsel <= '0;
         base <= '0;
         nonvolatile_mem_controller <= 1'b0;
         iosp <= 1'b0;
         rd <= BYTE_ZERO;
         flags <= FLAGS_RESET;
         io_addr <= '0;
         io_wdata <= BYTE_ZERO;
         io_re <= 1'b0;
         io_we <= 1'b0;
         debug_break <= 1'b0;
         sleep_req <= 1'b0;
         wdt_restart <= 1'b0;
         last_cycles <= '0;
      end else begin
         state <= next_state;
         op <= next_op;
         bsel <= next_bsel;
         base <= next_base;
         nonvolatile_mem_controller <= next_nvm;
         iosp <= next_iosp;
         rd <= next_rd;
         flags <= next_flags;
         io_addr <= next_io_addr;
         io_wdata <= next_io_wdata;
         io_re <= next_io_re;
         io_we <= next_io_we;
         debug_break <= next_debug_break;
         sleep_req <= next_sleep_req;
         wdt_restart <= next_wdt_restart;
         last_cycles <= next_last_cycles;
      end
   end

   // checks on executed operations
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   logic ex;
   assign ex = (state == st_exec);

   property p_rotl;
      ex && op == rotate_left_carry_op |=> state == st_idle &&
         rd == {$past(rd[6:0]), $past(flags[FLAG_C])} &&
         flags[FLAG_C] == $past(rd[7]);
   endproperty
   a_rotl: assert property (p_rotl) else $error("rotl wrong");

   property p_rotr;
      ex && op == rotate_right_carry_op |=>
         rd == {$past(flags[FLAG_C]), $past(rd[7:1])} &&
         flags[FLAG_C] == $past(rd[0]) &&
         flags[FLAG_H] == $past(flags[FLAG_H]);
   endproperty
   a_rotr: assert property (p_rotr) else $error("rotr wrong");

   sequence s_io_rmw;
      ex ##1 (state == st_io_write && io_re) ##1 (io_we && state == st_idle);
   endsequence
   property p_ioset;
      ex && op == io_bit_set_op |->
         s_io_rmw ##0 (io_wdata[bsel] && flags == $past(flags, 2));
   endproperty
   a_ioset: assert property (p_ioset) else $error("io set wrong");

   property p_ioclr;
      ex && op == io_bit_clear_op |-> s_io_rmw ##0 !io_wdata[bsel];
   endproperty
   a_ioclr: assert property (p_ioclr) else $error("io clr wrong");

   property p_tst;
      ex && op == bit_to_transfer_op |=>
         flags[FLAG_T] == $past(rd[bsel]) && state == st_idle;
   endproperty
   a_tst: assert property (p_tst) else $error("bit to t wrong");

   property p_tld;
      ex && op == transfer_to_bit_op |=>
         rd[bsel] == $past(flags[FLAG_T]) && flags == $past(flags);
   endproperty
   a_tld: assert property (p_tld) else $error("t to bit wrong");

   property p_vset;
      ex && op == overflow_set_op |=> flags[FLAG_V] &&
         (flags | 8'h08) == ($past(flags) | 8'h08);
   endproperty
   a_vset: assert property (p_vset) else $error("v set wrong");

   property p_hclr;
      ex && op == halfcarry_clear_op |=> !flags[FLAG_H] &&
         (flags & 8'hDF) == ($past(flags) & 8'hDF);
   endproperty
   a_hclr: assert property (p_hclr) else $error("h clr wrong");

   property p_lowio;
      ex && op == data_access_op && low_io && !nonvolatile_mem_controller && base == 3'h1 |->
         ##1 state == st_mem_wait ##1 state == st_idle;
   endproperty
   a_lowio: assert property (p_lowio) else $error("low io cycles wrong");
endmodule
`default_nettype wire

/* File: tb/bit_shift_flag_exec_unit_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module bit_shift_flag_exec_unit_tb_top
   import exec_unit_pkg::*;
;
   logic        clk;
   logic        reset;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  io_rdata;
   logic        nvm_busy;
   logic [7:0]  io_addr;
   logic [7:0]  io_wdata;
   logic        io_re;
   logic        io_we;
   logic        debug_break;
   logic        sleep_req;
   logic        wdt_restart;
   int          failures;
   int          num_checks;
   int          n_brk;
   int          n_slp;
   int          n_wdt;
   int          n_we;
   logic [7:0]  we_data;
   logic [7:0]  we_addr;
   logic        err;
   logic [31:0] q;
   logic [7:0]  msk [8] = '{8'h01, 8'h04, 8'h02, 8'h80,
                            8'h10, 8'h08, 8'h40, 8'h20};

   bit_shift_flag_exec_unit u_dut (
      .clk(clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .io_rdata(io_rdata),
      .nvm_busy(nvm_busy), .io_addr(io_addr), .io_wdata(io_wdata),
      .io_re(io_re), .io_we(io_we), .debug_break(debug_break),
      .sleep_req(sleep_req), .wdt_restart(wdt_restart)
   );

   // clock generation
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // pulse counters and i/o write capture
   always @(posedge clk) begin
      if (debug_break === 1'b1) n_brk++;
      if (sleep_req === 1'b1) n_slp++;
      if (wdt_restart === 1'b1) n_wdt++;
      if (io_we === 1'b1) begin
         n_we++;
         we_data = io_wdata;
         we_addr = io_addr;
      end
   end

   task automatic finish_test;
      if (failures == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) failures++;
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         apb(1'b0, STATE_OFS, 32'h0);
         n++;
      end while (q[STATE_BUSY_BIT] !== 1'b0 && n < 50);
      if (n >= 50) failures++;
   endtask

   // run one operation and compare operand, flags and cycle count
   task automatic op(input op_t o, input logic [2:0] b,
                     input logic [7:0] x, f, ex, ef, cyc);
      apb(1'b1, OPERAND_OFS, {24'h0, x});
      apb(1'b1, FLAGS_OFS, {24'h0, f});
      apb(1'b1, CMD_OFS, {21'h0, b, 2'h0, o});
      wait_idle;
      chk("cycles", {24'h0, q[7:0]}, {24'h0, cyc});
      apb(1'b0, OPERAND_OFS, 32'h0);
      chk("operand", q, {24'h0, ex});
      apb(1'b0, FLAGS_OFS, 32'h0);
      chk("flags", q, {24'h0, ef});
   endtask

   // data access with address, {iosp,nvm,0,base} and expected cycles
   task automatic da(input logic [7:0] a, input logic [5:0] hi,
                     input logic [7:0] cyc);
      apb(1'b1, ADDR_OFS, {24'h0, a});
      apb(1'b1, CMD_OFS, {14'h0, hi, 6'h0, data_access_op});
      wait_idle;
      chk("access cycles", {24'h0, q[7:0]}, {24'h0, cyc});
   endtask

   // watchdog against a hung run
   initial begin
      #100000;
      failures++;
      finish_test;
   end

   // main sequence
   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      io_rdata = 8'h55;
      nvm_busy = 1'b0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      apb(1'b0, FLAGS_OFS, 32'h0);
      chk("flags reset", q, {24'h0, FLAGS_RESET});
      apb(1'b0, OPERAND_OFS, 32'h0);
      chk("operand reset", q, 32'h0);
      op(logical_shift_left_op, 0, 8'h88, 8'h00, 8'h10, 8'h29, 1);
      op(logical_shift_right_op, 0, 8'h81, 8'h00, 8'h40, 8'h09, 1);
      op(arith_shift_right_op, 0, 8'h81, 8'h00, 8'hC0, 8'h05, 1);
      op(rotate_left_carry_op, 0, 8'h81, 8'h01, 8'h03, 8'h09, 1);
      op(rotate_left_carry_op, 0, 8'h08, 8'h00, 8'h10, 8'h20, 1);
      op(rotate_right_carry_op, 0, 8'h01, 8'h20, 8'h00, 8'h2B, 1);
      op(rotate_right_carry_op, 0, 8'h02, 8'h01, 8'h81, 8'h0C, 1);
      op(nibble_swap_op, 0, 8'hA5, 8'h3F, 8'h5A, 8'h3F, 1);
      op(bit_to_transfer_op, 4, 8'h10, 8'h00, 8'h10, 8'h40, 1);
      op(bit_to_transfer_op, 4, 8'hEF, 8'hFF, 8'hEF, 8'hBF, 1);
      op(transfer_to_bit_op, 7, 8'h00, 8'h40, 8'h80, 8'h40, 1);
      op(transfer_to_bit_op, 0, 8'hFF, 8'h00, 8'hFE, 8'h00, 1);
      op(generic_flag_set_op, 5, 8'h00, 8'h00, 8'h00, 8'h20, 1);
      op(generic_flag_clear_op, 2, 8'h00, 8'hFF, 8'h00, 8'hFB, 1);
      // dedicated set/clear pairs in flag order C N Z I S V T H
      for (int i = 0; i < 8; i++) begin
         op(op_t'(6'(13 + 2 * i)), 0, 8'h00, 8'h00, 8'h00, msk[i], 1);
         op(op_t'(6'(14 + 2 * i)), 0, 8'h00, 8'hFF, 8'h00, ~msk[i], 1);
      end
      op(break_op, 0, 8'h3C, 8'hA5, 8'h3C, 8'hA5, 1);
      chk("break pulses", n_brk, 1);
      op(sleep_op, 0, 8'h3C, 8'hA5, 8'h3C, 8'hA5, 1);
      chk("sleep pulses", n_slp, 1);
      op(watchdog_restart_op, 0, 8'h3C, 8'hA5, 8'h3C, 8'hA5, 1);
      chk("watchdog pulses", n_wdt, 1);
      apb(1'b1, ADDR_OFS, 32'h20);
      op(io_bit_set_op, 1, 8'h3C, 8'hA5, 8'h3C, 8'hA5, 2);
      chk("set data", {24'h0, we_data}, 32'h57);
      chk("set addr", {24'h0, we_addr}, 32'h20);
      op(io_bit_clear_op, 0, 8'h3C, 8'h5A, 8'h3C, 8'h5A, 2);
      chk("clear data", {24'h0, we_data}, 32'h54);
      chk("io writes", n_we, 2);
      da(8'h10, 6'h02, 8'h02);
      da(8'h10, 6'h22, 8'h03);
      da(8'h10, 6'h21, 8'h02);
      da(8'h40, 6'h22, 8'h02);
      da(8'h40, 6'h12, 8'h03);
      da(8'h10, 6'h32, 8'h04);
      da(8'h10, 6'h00, 8'h01);
      // controller busy for four extra edges at the end of the access
      nvm_busy <= 1'b1;
      fork
         begin
            repeat (12) @(posedge clk);
            nvm_busy <= 1'b0;
         end
      join_none
      da(8'h40, 6'h12, 8'h07);
      // write while busy is refused and has no effect
      apb(1'b1, FLAGS_OFS, 32'h0);
      apb(1'b1, CMD_OFS, {14'h0, 6'h07, 6'h0, data_access_op});
      apb(1'b1, FLAGS_OFS, 32'hFF);
      chk("busy write error", {31'h0, err}, 32'h1);
      wait_idle;
      apb(1'b0, FLAGS_OFS, 32'h0);
      chk("flags after refusal", q, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped data", q, 32'h0);
      chk("unmapped error", {31'h0, err}, 32'h1);
      finish_test;
   end
endmodule
`default_nettype wire
